// ### asd_top.sv
// Address generation and I/O / memory space decode for the core.
// Assumes one request per cycle at most, inputs synchronous to sys_clk.
// Overview of operation
// - I/O space is 64 KB, reached by byte, word or dword port transfers.
// - Every port input or output drives the memory/IO select low.
// - I/O port transfers force address bits 23:16 to zero; coprocessor ports set them to 80h.
// - Index goes to port 22h, data then moves through port 23h.
// - Accesses that hit a configuration register produce no external cycle.
// - Data port access without a fresh valid index goes external, no update.
// - Index writes outside C0h..CFh go external, clear idx_valid and touch no configuration register.
// - Reads of the index port always go external.
// - Memory space is 16 MB, with byte, word and dword transfers.
// - Multi-byte operands are little endian, addressed by their low byte.
// - Offset is base plus scaled index plus displacement, each optional.
// - Index comes from any register but the stack pointer, scaled 1/2/4/8.
// - Displacement is an immediate of up to 32 bits.
// - Only the nine base/index/scale/displacement forms are accepted.
// - Real mode adds segment times 16 to a 16-bit offset.
// - The carry of the real-mode sum is kept, giving 21 address bits.
// - A real-mode address beyond 1 MB raises a limit overrun pulse.
// - Escape opcodes reach coprocessor ports 80_00F8h..80_00FFh.
`timescale 1ns/10ps
`default_nettype none
module asd_top #(
    parameter int CFG_N = asd_pkg::CFG_COUNT
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire asd_pkg::asd_kind_t req_kind,
    input  wire logic              req_write,
    input  wire logic [1:0]        req_size,
    input  wire logic [15:0]       req_port,
    input  wire logic [2:0]        req_esc_port,
    input  wire logic [31:0]       req_wdata,
    input  wire logic              req_real,
    input  wire logic [15:0]       req_seg,
    input  wire logic              base_en,
    input  wire logic [31:0]       base_val,
    input  wire logic              idx_en,
    input  wire logic [2:0]        idx_reg,
    input  wire logic [31:0]       idx_val,
    input  wire logic [1:0]        scale,
    input  wire logic              disp_en,
    input  wire logic [31:0]       disp_val,
    output logic                   bus_cyc,
    output logic                   bus_mio_n,
    output logic                   bus_write,
    output logic [23:0]            bus_addr,
    output logic [3:0]             bus_be,
    output logic [31:0]            bus_wdata,
    output logic                   int_done,
    output logic [7:0]             int_rdata,
    output logic                   idx_valid,
    output logic                   limit_exc,
    output logic                   form_fault
);
    asd_ea_if eif ();

    asd_ea u_ea (
        .eif (eif)
    );

    assign eif.base_en  = base_en;
    assign eif.base_val = base_val;
    assign eif.idx_en   = idx_en;
    assign eif.idx_reg  = idx_reg;
    assign eif.idx_val  = idx_val;
    assign eif.scale    = scale;
    assign eif.disp_en  = disp_en;
    assign eif.disp_val = disp_val;

    logic        bus_cyc_r,   bus_cyc_nxt;
    logic        mio_n_r,     mio_n_nxt;
    logic        write_r,     write_nxt;
    logic [23:0] addr_r,      addr_nxt;
    logic [3:0]  be_r,        be_nxt;
    logic [31:0] wdata_r,     wdata_nxt;
    logic        done_r,      done_nxt;
    logic [7:0]  rdata_r,     rdata_nxt;
    logic        ivalid_r,    ivalid_nxt;
    logic [3:0]  index_r,     index_nxt;
    logic        limit_r,     limit_nxt;
    logic        fault_r,     fault_nxt;
    logic        cfg_we;
    logic [7:0]  cfg_mem_r [CFG_N];
    logic [20:0] real_sum;
    logic        idx_in_range;

    // Byte enables follow the low address bits so the low byte sits lowest
    function automatic logic [3:0] be_of(input logic [1:0] sz,
                                         input logic [1:0] a);
        logic [3:0] m;
        m = asd_pkg::BE_BYTE;
        if (sz == asd_pkg::SZ_WORD)
            m = asd_pkg::BE_WORD;
        else if (sz == asd_pkg::SZ_DWORD)
            m = asd_pkg::BE_DWORD;
        return m << a;
    endfunction

    always_comb
    begin
        // Carry kept rather than wrapped so the area above 1 MB is reachable
        real_sum = {1'b0, req_seg, 4'h0000} + {5'h0000, eif.ea[15:0]};
        idx_in_range = req_wdata[7:0] >= asd_pkg::CFG_IDX_LO
                    && req_wdata[7:0] <= asd_pkg::CFG_IDX_HI;
    end

    always_comb
    begin
        bus_cyc_nxt = 1'b0;
        mio_n_nxt   = mio_n_r;
        write_nxt   = write_r;
        addr_nxt    = addr_r;
        be_nxt      = be_r;
        wdata_nxt   = wdata_r;
        done_nxt    = 1'b0;
        rdata_nxt   = rdata_r;
        ivalid_nxt  = ivalid_r;
        index_nxt   = index_r;
        limit_nxt   = 1'b0;
        fault_nxt   = 1'b0;
        cfg_we      = 1'b0;
        if (req_valid)
        begin
            write_nxt = req_write;
            wdata_nxt = req_wdata;
            be_nxt    = be_of(req_size, 2'b00);
            unique case (req_kind)
                asd_pkg::ASD_KIND_IO:
                begin
                    mio_n_nxt = 1'b0;
                    addr_nxt  = {8'h0000, req_port};
                    be_nxt    = be_of(req_size, req_port[1:0]);
                    if (req_port == asd_pkg::PORT_INDEX)
                    begin
                        if (req_write && idx_in_range)
                        begin
                            ivalid_nxt = 1'b1;
                            index_nxt  = req_wdata[3:0];
                            done_nxt   = 1'b1;
                        end
                        else
                        begin
                            bus_cyc_nxt = 1'b1;
                            if (req_write)
                                ivalid_nxt = 1'b0;
                        end
                    end
                    else if (req_port == asd_pkg::PORT_DATA)
                    begin
                        ivalid_nxt = 1'b0;
                        if (ivalid_r)
                        begin
                            done_nxt = 1'b1;
                            cfg_we   = req_write;
                            if (!req_write)
                                rdata_nxt = cfg_mem_r[index_r];
                        end
                        else
                            bus_cyc_nxt = 1'b1;
                    end
                    else
                        bus_cyc_nxt = 1'b1;
                end
                asd_pkg::ASD_KIND_ESC:
                begin
                    // Coprocessor ports sit above the plain 64 KB I/O space
                    mio_n_nxt   = 1'b0;
                    addr_nxt    = {asd_pkg::ESC_BASE[23:3], req_esc_port};
                    be_nxt      = be_of(req_size, 2'b00);
                    bus_cyc_nxt = 1'b1;
                end
                asd_pkg::ASD_KIND_MEM:
                begin
                    mio_n_nxt = 1'b1;
                    be_nxt    = be_of(req_size, eif.ea[1:0]);
                    if (req_real)
                    begin
                        addr_nxt  = {3'h0000, real_sum};
                        limit_nxt = real_sum[asd_pkg::REAL_CARRY];
                    end
                    else
                        addr_nxt = eif.ea[23:0];
                    // Malformed forms never reach the bus
                    fault_nxt   = eif.form_bad;
                    bus_cyc_nxt = !eif.form_bad;
                end
                default:
                begin
                    fault_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bus_cyc_r <= 1'b0;
            mio_n_r   <= 1'b1;
            write_r   <= 1'b0;
            addr_r    <= 24'h00_0000;
            be_r      <= 4'h0000;
            wdata_r   <= 32'h0000_0000;
            done_r    <= 1'b0;
            rdata_r   <= 8'h0000;
            ivalid_r  <= 1'b0;
            index_r   <= 4'h0000;
            limit_r   <= 1'b0;
            fault_r   <= 1'b0;
        end
        else
        begin
            bus_cyc_r <= bus_cyc_nxt;
            mio_n_r   <= mio_n_nxt;
            write_r   <= write_nxt;
            addr_r    <= addr_nxt;
            be_r      <= be_nxt;
            wdata_r   <= wdata_nxt;
            done_r    <= done_nxt;
            rdata_r   <= rdata_nxt;
            ivalid_r  <= ivalid_nxt;
            index_r   <= index_nxt;
            limit_r   <= limit_nxt;
            fault_r   <= fault_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < CFG_N; i++)
                cfg_mem_r[i] <= asd_pkg::CFG_RESET;
        end
        else if (cfg_we)
            cfg_mem_r[index_r] <= req_wdata[7:0];
    end

    assign bus_cyc    = bus_cyc_r;
    assign bus_mio_n  = mio_n_r;
    assign bus_write  = write_r;
    assign bus_addr   = addr_r;
    assign bus_be     = be_r;
    assign bus_wdata  = wdata_r;
    assign int_done   = done_r;
    assign int_rdata  = rdata_r;
    assign idx_valid  = ivalid_r;
    assign limit_exc  = limit_r;
    assign form_fault = fault_r;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic io_req;
    logic [31:0] ea_ref;
    assign io_req = req_valid && req_kind == asd_pkg::ASD_KIND_IO;
    assign ea_ref = (base_en ? base_val : 32'h0000_0000)
                  + (idx_en ? (idx_val << scale) : 32'h0000_0000)
                  + (disp_en ? disp_val : 32'h0000_0000);

    a_io_sel_low: assert property (io_req |=> !bus_mio_n)
        else $error("I/O access did not drive select low");
    a_io_upper_zero: assert property (io_req |=> bus_addr[23:16] == 8'h0000)
        else $error("I/O access with nonzero upper address");
    a_cfg_internal: assert property (io_req && req_port == asd_pkg::PORT_DATA
        && idx_valid |=> int_done && !bus_cyc)
        else $error("Armed data port access went external");
    a_data_unarmed: assert property (io_req && req_port == asd_pkg::PORT_DATA
        && !idx_valid |=> bus_cyc && !int_done && !idx_valid)
        else $error("Unarmed data port access not external");
    a_index_range: assert property (io_req && req_write
        && req_port == asd_pkg::PORT_INDEX && !idx_in_range
        |=> bus_cyc && !idx_valid)
        else $error("Out of range index not passed out");
    a_index_read: assert property (io_req && !req_write
        && req_port == asd_pkg::PORT_INDEX |=> bus_cyc && !int_done)
        else $error("Index port read answered internally");
    a_index_arm: assert property (io_req && req_write
        && req_port == asd_pkg::PORT_INDEX && idx_in_range
        |=> idx_valid && !bus_cyc ##1 idx_valid || $past(req_valid))
        else $error("Valid index write did not arm");
    a_real_form: assert property (req_valid && req_kind == asd_pkg::ASD_KIND_MEM
        && req_real |=> bus_addr == {3'h0000, $past(real_sum)}
        && limit_exc == bus_addr[20])
        else $error("Real mode address or limit wrong");
    a_flat_sum: assert property (req_valid && req_kind == asd_pkg::ASD_KIND_MEM
        && !req_real |=> bus_addr == $past(ea_ref[23:0]) && bus_mio_n)
        else $error("Offset sum wrong");
    a_esc_range: assert property (req_valid && req_kind == asd_pkg::ASD_KIND_ESC
        |=> bus_cyc && bus_addr[23:3] == asd_pkg::ESC_BASE[23:3])
        else $error("Coprocessor port outside range");
endmodule // asd_top
`default_nettype wire

// ### asd_pkg.sv
// Constants shared by the address-space decode block.
// Assumes a single core clock and a 24-bit external address bus.
package asd_pkg;

    localparam int          IO_ADDR_W    = 16;
    localparam int          MEM_ADDR_W   = 24;
    localparam logic [15:0] PORT_INDEX   = 16'h0022;
    localparam logic [15:0] PORT_DATA    = 16'h0023;
    localparam logic [7:0]  CFG_IDX_LO   = 8'h00C0;
    localparam logic [7:0]  CFG_IDX_HI   = 8'h00CF;
    localparam logic [7:0]  CFG_RESET    = 8'h0000;
    localparam int          CFG_COUNT    = 16;
    localparam logic [23:0] ESC_BASE     = 24'h80_00F8;
    localparam logic [2:0]  REG_ESP      = 3'h0004;
    localparam int          REAL_CARRY   = 20;
    localparam logic [1:0]  SZ_BYTE      = 2'h0000;
    localparam logic [1:0]  SZ_WORD      = 2'h0001;
    localparam logic [1:0]  SZ_DWORD     = 2'h0002;
    localparam logic [3:0]  BE_BYTE      = 4'h0001;
    localparam logic [3:0]  BE_WORD      = 4'h0003;
    localparam logic [3:0]  BE_DWORD     = 4'h000F;

    typedef enum logic [1:0] {
        ASD_KIND_IO,
        ASD_KIND_MEM,
        ASD_KIND_ESC
    } asd_kind_t;

endpackage

// ### asd_ea_if.sv
// Operand and result bundle between the decode top and the offset adder.
// Assumes the operands are stable for the cycle in which they are used.
`timescale 1ns/10ps
`default_nettype none
interface asd_ea_if;
    logic        base_en;
    logic [31:0] base_val;
    logic        idx_en;
    logic [2:0]  idx_reg;
    logic [31:0] idx_val;
    logic [1:0]  scale;
    logic        disp_en;
    logic [31:0] disp_val;
    logic [31:0] ea;
    logic        form_bad;

    modport calc (
        input  base_en, base_val, idx_en, idx_reg, idx_val, scale,
        input  disp_en, disp_val,
        output ea, form_bad
    );
    modport user (
        output base_en, base_val, idx_en, idx_reg, idx_val, scale,
        output disp_en, disp_val,
        input  ea, form_bad
    );
endinterface
`default_nettype wire

// ### asd_ea.sv
// Offset (effective address) adder: base + scaled index + displacement.
// Assumes the caller registers the result; this module is combinational.
`timescale 1ns/10ps
`default_nettype none
module asd_ea (
    asd_ea_if.calc eif
);
    logic [31:0] scaled;
    logic [31:0] base_term;
    logic [31:0] idx_term;
    logic [31:0] disp_term;

    always_comb
    begin
        scaled    = eif.idx_val << eif.scale;
        base_term = eif.base_en ? eif.base_val : 32'h0000_0000;
        idx_term  = eif.idx_en ? scaled : 32'h0000_0000;
        disp_term = eif.disp_en ? eif.disp_val : 32'h0000_0000;
        eif.ea    = base_term + idx_term + disp_term;
        // Only the nine legal forms pass; a bare index needs a displacement
        eif.form_bad = (eif.idx_en && eif.idx_reg == asd_pkg::REG_ESP)
                     || (!eif.base_en && !eif.idx_en && !eif.disp_en)
                     || (eif.idx_en && !eif.base_en && !eif.disp_en);
    end
endmodule // asd_ea
`default_nettype wire

// ### asd_sysbus_model.sv
// System bus far side: I/O and memory cycle counters and a small byte-wide memory.
// Assumes bus_cyc is a one-cycle pulse with address and enables beside it.
`timescale 1ns/10ps
`default_nettype none
module asd_sysbus_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        bus_cyc,
    input  wire logic        bus_mio_n,
    input  wire logic        bus_write,
    input  wire logic [23:0] bus_addr,
    input  wire logic [3:0]  bus_be,
    input  wire logic [31:0] bus_wdata,
    input  wire logic [7:0]  peek_addr,
    output logic      [15:0] io_cycles,
    output logic      [15:0] mem_cycles,
    output logic      [7:0]  peek_data
);
    // Only 256 bytes are kept; upper address bits alias to stay cheap
    logic [7:0] mem [256];

    assign peek_data = mem[peek_addr];

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            io_cycles  <= 16'h0000;
            mem_cycles <= 16'h0000;
        end
        else if (bus_cyc)
        begin
            if (!bus_mio_n)
                io_cycles <= io_cycles + 16'h0001;
            else
                mem_cycles <= mem_cycles + 16'h0001;
            if (bus_mio_n && bus_write)
                for (int k = 0; k < 4; k++)
                    if (bus_be[k])
                        mem[{bus_addr[7:2], k[1:0]}] <= bus_wdata[8*k +: 8];
        end
    end
endmodule // asd_sysbus_model
`default_nettype wire

// ### address_space_decode_bench.sv
// Self-checking bench for the address-space decode block.
// Assumes asd_pkg, asd_ea_if, asd_ea and asd_top are compiled first.
`timescale 1ns/10ps
`default_nettype none
module address_space_decode_bench;
    logic               sys_clk, rst, req_valid, req_write, req_real;
    asd_pkg::asd_kind_t req_kind;
    logic [1:0]         req_size, scale;
    logic [15:0]        req_port, req_seg, io_cycles, mem_cycles;
    logic [2:0]         req_esc_port, idx_reg;
    logic [31:0]        req_wdata, base_val, idx_val, disp_val, bus_wdata;
    logic               base_en, idx_en, disp_en;
    logic               bus_cyc, bus_mio_n, bus_write, int_done;
    logic               idx_valid, limit_exc, form_fault;
    logic [23:0]        bus_addr;
    logic [3:0]         bus_be;
    logic [7:0]         int_rdata, peek_addr, peek_data;
    logic               g_cyc, g_done, g_flt, g_exc;
    int                 errors, num_checks;
    localparam logic [4:0] FM [9] = '{5'h04, 5'h10, 5'h14, 5'h0C, 5'h0E,
                                      5'h18, 5'h1B, 5'h1C, 5'h1D};

    asd_top dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
        .req_kind(req_kind), .req_write(req_write), .req_size(req_size),
        .req_port(req_port), .req_esc_port(req_esc_port),
        .req_wdata(req_wdata), .req_real(req_real), .req_seg(req_seg),
        .base_en(base_en), .base_val(base_val), .idx_en(idx_en),
        .idx_reg(idx_reg), .idx_val(idx_val), .scale(scale),
        .disp_en(disp_en), .disp_val(disp_val), .bus_cyc(bus_cyc),
        .bus_mio_n(bus_mio_n), .bus_write(bus_write), .bus_addr(bus_addr),
        .bus_be(bus_be), .bus_wdata(bus_wdata), .int_done(int_done),
        .int_rdata(int_rdata), .idx_valid(idx_valid),
        .limit_exc(limit_exc), .form_fault(form_fault));

    asd_sysbus_model far (.sys_clk(sys_clk), .rst(rst), .bus_cyc(bus_cyc),
        .bus_mio_n(bus_mio_n), .bus_write(bus_write), .bus_addr(bus_addr),
        .bus_be(bus_be), .bus_wdata(bus_wdata), .peek_addr(peek_addr),
        .io_cycles(io_cycles), .mem_cycles(mem_cycles),
        .peek_data(peek_data));

    initial
    begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One request; outputs are caught within a bounded number of cycles
    task automatic rq(input asd_pkg::asd_kind_t k, input logic w,
                      input logic [1:0] s, input logic [15:0] p,
                      input logic [31:0] d);
        logic got;
        got = 0;
        req_valid = 1;
        req_kind = k;
        req_write = w;
        req_size = s;
        req_port = p;
        req_wdata = d;
        @(posedge sys_clk);
        #1 req_valid = 0;
        for (int n = 0; n < 3 && !got; n++)
        begin
            if (bus_cyc === 1 || int_done === 1 || form_fault === 1)
                got = 1;
            else
            begin
                @(posedge sys_clk);
                #1;
            end
        end
        g_cyc = bus_cyc;
        g_done = int_done;
        g_flt = form_fault;
        g_exc = limit_exc;
        // One idle edge, so the next call never re-raises valid in this step
        @(posedge sys_clk);
        #1;
        if (!got)
        begin
            $display("[FAIL] answer expected 1 seen 0");
            errors++;
            wrap_up();
        end
    endtask

    task automatic ops(input logic b, i, dd, input logic [2:0] r,
                       input logic [1:0] sc);
        base_en = b;
        idx_en = i;
        disp_en = dd;
        idx_reg = r;
        scale = sc;
    endtask

    task automatic t_config();
        logic [15:0] io0;
        io0 = io_cycles;
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022,
           32'h0000_00C5);
        check("done", g_done, 1);
        check("cyc", g_cyc, 0);
        check("idx_valid", idx_valid, 1);
        check("mio_n", bus_mio_n, 0);
        check("addr", bus_addr, 24'h00_0022);
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0023, 32'h0000_00AB);
        check("done", g_done, 1);
        check("idx_valid", idx_valid, 0);
        // Second data access without a fresh index must leave the chip
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0023, 32'h0000_0055);
        check("cyc", g_cyc, 1);
        check("done", g_done, 0);
        rq(asd_pkg::ASD_KIND_IO, 0, asd_pkg::SZ_BYTE, 16'h0023, 32'h0000_0000);
        check("cyc", g_cyc, 1);
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022,
           32'h0000_00C5);
        rq(asd_pkg::ASD_KIND_IO, 0, asd_pkg::SZ_BYTE, 16'h0023, 32'h0000_0000);
        check("done", g_done, 1);
        check("rdata", int_rdata, 8'hAB);
        check("io count", io_cycles - io0, 16'h0002);
        $display("test config done");
    endtask

    task automatic t_index();
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022, 32'h0000_00CF);
        check("idx_valid", idx_valid, 1);
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022, 32'h0000_00D0);
        check("cyc", g_cyc, 1);
        check("idx_valid", idx_valid, 0);
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022, 32'h0000_00BF);
        check("cyc", g_cyc, 1);
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022, 32'h0000_00C0);
        rq(asd_pkg::ASD_KIND_IO, 0, asd_pkg::SZ_BYTE, 16'h0022, 32'h0000_0000);
        check("cyc", g_cyc, 1);
        check("idx_valid", idx_valid, 1);
        $display("test index done");
    endtask

    task automatic t_io();
        logic [3:0] be [3];
        be = '{asd_pkg::BE_BYTE, asd_pkg::BE_WORD, asd_pkg::BE_DWORD};
        for (int s = 0; s < 3; s++)
        begin
            rq(asd_pkg::ASD_KIND_IO, 0, s[1:0], 16'hFFFC, 32'h0000_0000);
            check("mio_n", bus_mio_n, 0);
            check("addr", bus_addr, 24'h00_FFFC);
            check("be", bus_be, be[s]);
        end
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'hFFFD, 32'h0000_0000);
        check("be", bus_be, 4'h2);
        for (int p = 0; p < 8; p++)
        begin
            req_esc_port = p[2:0];
            rq(asd_pkg::ASD_KIND_ESC, 0, asd_pkg::SZ_WORD, 16'h0000,
               32'h0000_0000);
            check("esc addr", bus_addr, asd_pkg::ESC_BASE + p);
            check("esc mio_n", bus_mio_n, 0);
        end
        $display("test io done");
    endtask

    task automatic t_mem();
        logic [31:0] e;
        req_real = 0;
        for (int f = 0; f < 9; f++)
        begin
            ops(FM[f][4], FM[f][3], FM[f][2], 3'h1, FM[f][1:0]);
            e = (FM[f][4] ? base_val : 0) + (FM[f][2] ? disp_val : 0)
              + (FM[f][3] ? idx_val << FM[f][1:0] : 0);
            rq(asd_pkg::ASD_KIND_MEM, 0, asd_pkg::SZ_BYTE, 16'h0000, 0);
            check("form addr", bus_addr, e[23:0]);
            check("form be", bus_be, 4'h1 << e[1:0]);
            check("mem mio_n", bus_mio_n, 1);
        end
        ops(0, 0, 0, 3'h1, 2'h0);
        rq(asd_pkg::ASD_KIND_MEM, 0, asd_pkg::SZ_BYTE, 16'h0000, 0);
        check("fault", g_flt, 1);
        check("cyc", g_cyc, 0);
        ops(1, 1, 0, asd_pkg::REG_ESP, 2'h0);
        rq(asd_pkg::ASD_KIND_MEM, 0, asd_pkg::SZ_BYTE, 16'h0000, 0);
        check("fault", g_flt, 1);
        rq(asd_pkg::asd_kind_t'(2'h3), 0, asd_pkg::SZ_BYTE, 16'h0000, 0);
        check("kind fault", g_flt, 1);
        check("kind cyc", g_cyc, 0);
        ops(1, 0, 0, 3'h1, 2'h0);
        base_val = 32'hFF00_0040;
        peek_addr = 8'h40;
        rq(asd_pkg::ASD_KIND_MEM, 1, asd_pkg::SZ_DWORD, 16'h0000,
           32'h1122_3344);
        check("dword be", bus_be, 4'hF);
        check("addr", bus_addr, 24'h00_0040);
        check("write", bus_write, 1);
        check("wdata", bus_wdata, 32'h1122_3344);
        @(posedge sys_clk);
        #1 check("low byte", peek_data, 8'h44);
        ops(0, 0, 1, 3'h1, 2'h0);
        req_real = 1;
        req_seg = 16'h1234;
        rq(asd_pkg::ASD_KIND_MEM, 0, asd_pkg::SZ_BYTE, 16'h0000, 0);
        check("real addr", bus_addr, 24'h01_2345);
        check("exc", g_exc, 0);
        req_seg = 16'hFFFF;
        disp_val = 32'h0000_0010;
        rq(asd_pkg::ASD_KIND_MEM, 0, asd_pkg::SZ_BYTE, 16'h0000, 0);
        check("carry addr", bus_addr, 24'h10_0000);
        check("exc", g_exc, 1);
        $display("test mem done");
    endtask

    // Reset in mid-run must drop the armed index and clear the registers
    task automatic t_reset();
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022,
           32'h0000_00C3);
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0023,
           32'h0000_005A);
        check("done", g_done, 1);
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022,
           32'h0000_00C3);
        rst = 1;
        @(posedge sys_clk);
        #1 rst = 0;
        check("reset idx_valid", idx_valid, 0);
        rq(asd_pkg::ASD_KIND_IO, 0, asd_pkg::SZ_BYTE, 16'h0023,
           32'h0000_0000);
        check("cyc", g_cyc, 1);
        rq(asd_pkg::ASD_KIND_IO, 1, asd_pkg::SZ_BYTE, 16'h0022,
           32'h0000_00C3);
        rq(asd_pkg::ASD_KIND_IO, 0, asd_pkg::SZ_BYTE, 16'h0023,
           32'h0000_0000);
        check("done", g_done, 1);
        check("reset cfg", int_rdata, asd_pkg::CFG_RESET);
        $display("test reset done");
    endtask

    initial
    begin
        errors = 0;
        num_checks = 0;
        rst = 1;
        req_valid = 0;
        req_kind = asd_pkg::ASD_KIND_IO;
        {req_write, req_real, base_en, idx_en, disp_en} = 5'h00;
        {req_size, scale, req_esc_port, idx_reg} = 10'h000;
        {req_port, req_seg, req_wdata} = 64'h0000_0000_0000_0000;
        base_val = 32'h0012_3400;
        idx_val = 32'h0000_0010;
        disp_val = 32'h0000_0005;
        peek_addr = 8'h00;
        repeat (3) @(posedge sys_clk);
        #1 rst = 0;
        check("reset mio_n", bus_mio_n, 1);
        check("reset idx_valid", idx_valid, 0);
        t_config();
        t_index();
        t_io();
        t_mem();
        t_reset();
        wrap_up();
    end

    initial
    begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule // address_space_decode_bench
`default_nettype wire
